// File: hdl/mcer_channel.sv
// Functional notes
// - No memory command until software marks DRAM configuration done.
// - Transaction succeeds when no alert returns within one round trip.
// - Bad CRC or bad write ack: fast reset, then retry outstanding commands.
// - Second consecutive failure of the same transaction is fatal.
// - Failed configuration read aborts with all ones, never retried.
// - Channel index logs branch: 0 for branch 0, 2 for branch 1.
// - Locator bits 8:0 mean even channel, 17:9 odd channel.
// - Uncorrectable errors log failing rank in nonrecoverable log.
// - Dual-channel code: 32 data symbols plus 4 check symbols, systematic.
// - Errors within one adjacent symbol pair are correctable, except odd-channel pairs 17:9 in single-channel mode.
// - Address bit 4 selects which nibble of each symbol moves first.
// - Single channel: nine-byte code words, eight per cache line.
// - Refreshes rotate over eight ranks, each within eight intervals.
// - Every memory access is 64 bytes.
// - Burst length 4, interleaved, 32 bytes per burst.
// - Column commands use posted-CAS timing.
// - Never two ranks driving data at once.
// - Write bursts are never cut short for reads.
// - Precharge never terminates a burst early.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mcer_channel (
	input  wire logic                    clk_sys_i,
	input  wire logic                    srst_i,
	input  wire logic [7:0]              reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_we_i,
	input  wire logic                    reg_re_i,
	output logic      [31:0]             reg_rdata_o,
	input  wire logic                    req_valid_i,
	input  wire mcer_pkg::mcer_req_s     req_i,
	output logic                         req_ready_o,
	output logic                         cmd_valid_o,
	output mcer_pkg::mcer_cmd_s          cmd_o,
	input  wire mcer_pkg::mcer_nb_s      nb_i,
	input  wire mcer_pkg::mcer_ecc_evt_s ecc_evt_i,
	input  wire logic [143:0]            xfer0_i,
	input  wire logic [143:0]            xfer1_i,
	input  wire logic                    xfer_upper_i,
	output logic      [255:0]            data_symbols_o,
	output logic      [31:0]             check_symbols_o,
	output logic                         cpl_valid_o,
	output mcer_pkg::mcer_cpl_s          cpl_o,
	output logic                         fast_reset_o,
	output logic                         fatal_o
);
	import mcer_pkg::*;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	logic [31:0] ctrl_d, ctrl_q;
	logic [31:0] rdata_d, rdata_q;
	logic        ferr_clr;
	logic        ferr_valid;
	logic [1:0]  chan_idx;
	logic [2:0]  rec_rank;
	logic [17:0] rec_loc;
	logic [2:0]  nrec_rank;
	logic        cfg_done;
	mcer_state_e state_d, state_q;
	logic [3:0]  cnt_d, cnt_q;

	assign cfg_done = ctrl_q[CTRL_CFGDONE];

	always_comb begin
		ctrl_d   = ctrl_q;
		rdata_d  = '0;
		ferr_clr = reg_we_i && reg_addr_i == REG_FERR && reg_wdata_i[FERR_VALID];
		if (reg_we_i && reg_addr_i == REG_CTRL) begin
			ctrl_d = reg_wdata_i;
		end
		if (reg_re_i) begin
			unique case (reg_addr_i)
				REG_CTRL:   rdata_d = ctrl_q;
				REG_STATUS: rdata_d = {24'h00_0000, cnt_q, fatal_o, 1'b0, state_q};
				REG_FERR:   rdata_d = {29'h0, ferr_valid, chan_idx};
				REG_RECA:   rdata_d = {29'h0, rec_rank};
				REG_RECB:   rdata_d = {14'h0, rec_loc};
				REG_NRECA:  rdata_d = {29'h0, nrec_rank};
				default:    rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctrl_q  <= {TREF_RST, 16'h0000};
			rdata_q <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata_o = rdata_q;

	// ----------------------------------------
	// ECC layout and logs
	// ----------------------------------------
	mcer_ecc_log u_ecc (
		.clk_sys_i       (clk_sys_i),
		.srst_i          (srst_i),
		.evt_i           (ecc_evt_i),
		.single_i        (ctrl_q[CTRL_SINGLE]),
		.ferr_clr_i      (ferr_clr),
		.xfer0_i         (xfer0_i),
		.xfer1_i         (xfer1_i),
		.crit_upper_i    (xfer_upper_i),
		.data_symbols_o  (data_symbols_o),
		.check_symbols_o (check_symbols_o),
		.ferr_valid_o    (ferr_valid),
		.chan_idx_o      (chan_idx),
		.rec_rank_o      (rec_rank),
		.rec_loc_o       (rec_loc),
		.nrec_rank_o     (nrec_rank)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	mcer_cmd_s   rb_d [RPLY_DEPTH];
	mcer_cmd_s   rb_q [RPLY_DEPTH];
	logic [7:0]  stamp_d [RPLY_DEPTH];
	logic [7:0]  stamp_q [RPLY_DEPTH];
	logic [2:0]  head_d, head_q, tail_d, tail_q, rp_d, rp_q;
	logic [3:0]  left_d, left_q;
	logic [7:0]  now_d, now_q, frst_d, frst_q, age;
	logic [2:0]  busy_d, busy_q;
	logic [15:0] ref_cnt_d, ref_cnt_q;
	logic        ref_pend_d, ref_pend_q;
	logic [2:0]  ref_rank_d, ref_rank_q;
	logic        retried_d, retried_q;
	logic [31:0] hdata_d, hdata_q;
	logic        cmd_valid_d;
	mcer_cmd_s   cmd_d, head;
	logic        cpl_valid_d;
	mcer_cpl_s   cpl_d;
	logic        fail, push, pop, retire;

	function automatic mcer_cmd_s mk_cmd(input mcer_req_s r);
		mcer_cmd_s c;
		c.kind       = r.kind;
		c.tag        = r.tag;
		c.rank       = r.rank;
		c.addr       = r.addr;
		c.crit_upper = r.addr[4];
		c.posted_cas = 1'b1;
		c.burst_len  = BURST_LEN;
		c.bytes      = ACCESS_SZ;
		return c;
	endfunction

	function automatic logic is_col(input mcer_kind_e k);
		return k == KIND_RD || k == KIND_WR;
	endfunction

	always_comb begin
		head   = rb_q[head_q];
		age    = now_q - stamp_q[head_q];
		fail   = nb_i.valid && (nb_i.alert || !nb_i.crc_ok || (nb_i.is_ack && !nb_i.ack_ok));
		retire = state_q == ST_RUN && cnt_q != '0 && !fail && age >= RTT_CNT;
		req_ready_o = state_q == ST_RUN && cfg_done && busy_q == '0 && !ref_pend_q
		              && !fail && cnt_q < RPLY_DEPTH;
		push        = req_valid_i && req_ready_o;
		pop         = retire;
		rb_d        = rb_q;
		stamp_d     = stamp_q;
		state_d     = state_q;
		head_d      = head_q;
		tail_d      = tail_q;
		rp_d        = rp_q;
		left_d      = left_q;
		frst_d      = frst_q;
		now_d       = now_q + 8'h01;
		busy_d      = (busy_q != '0) ? busy_q - 3'h1 : busy_q;
		ref_cnt_d   = ref_cnt_q;
		ref_pend_d  = ref_pend_q;
		ref_rank_d  = ref_rank_q;
		retried_d   = retried_q;
		hdata_d     = hdata_q;
		cmd_valid_d = 1'b0;
		cmd_d       = cmd_o;
		cpl_valid_d = 1'b0;
		cpl_d       = cpl_o;
		if (nb_i.valid && !fail && !nb_i.is_ack) begin
			hdata_d = nb_i.data;
		end
		if (state_q != ST_FRST) begin
			if (ref_cnt_q == '0) begin
				ref_cnt_d  = ctrl_q[CTRL_TREF +: 16];
				ref_pend_d = 1'b1;
			end else begin
				ref_cnt_d = ref_cnt_q - 16'h0001;
			end
		end
		if (fail && cnt_q != '0 && (state_q == ST_RUN || state_q == ST_REPLAY)) begin
			if (head.kind == KIND_CFG_RD) begin
				pop         = 1'b1;
				retried_d   = 1'b0;
				cpl_valid_d = 1'b1;
				cpl_d       = '{tag: head.tag, abort: 1'b1, data: ALL_ONES};
			end else if (retried_q) begin
				state_d = ST_FATAL;
			end else begin
				retried_d = 1'b1;
				state_d   = ST_FRST;
				frst_d    = FRST_CNT - 8'h01;
			end
		end
		if (retire) begin
			retried_d = 1'b0;
			if (head.kind == KIND_RD || head.kind == KIND_CFG_RD) begin
				cpl_valid_d = 1'b1;
				cpl_d       = '{tag: head.tag, abort: 1'b0, data: hdata_q};
			end
		end
		unique case (state_q)
			ST_RUN: begin
				if (cfg_done && busy_q == '0 && !fail && ref_pend_q) begin
					cmd_valid_d = 1'b1;
					cmd_d       = mk_cmd(mcer_req_s'{kind: KIND_REF, tag: 4'h0, rank: ref_rank_q, addr: 32'h0000_0000});
					ref_pend_d  = 1'b0;
					ref_rank_d  = ref_rank_q + 3'h1;
				end else if (push) begin
					cmd_valid_d     = 1'b1;
					cmd_d           = mk_cmd(req_i);
					rb_d[tail_q]    = mk_cmd(req_i);
					stamp_d[tail_q] = now_q;
					tail_d          = tail_q + 3'h1;
					if (is_col(req_i.kind)) begin
						busy_d = BUSY_CNT;
					end
				end
			end
			ST_FRST: begin
				if (frst_q == '0) begin
					state_d = ST_REPLAY;
					rp_d    = head_q;
					left_d  = cnt_q;
				end else begin
					frst_d = frst_q - 8'h01;
				end
			end
			ST_REPLAY: begin
				if (state_d == ST_REPLAY) begin
					if (left_q == '0) begin
						state_d = ST_RUN;
					end else if (busy_q == '0) begin
						cmd_valid_d   = 1'b1;
						cmd_d         = rb_q[rp_q];
						stamp_d[rp_q] = now_q;
						rp_d          = rp_q + 3'h1;
						left_d        = left_q - 4'h1;
						if (is_col(rb_q[rp_q].kind)) begin
							busy_d = BUSY_CNT;
						end
					end
				end
			end
			ST_FATAL: begin
				state_d = ST_FATAL;
			end
		endcase
		if (pop) begin
			head_d = head_q + 3'h1;
		end
		cnt_d = cnt_q + {3'h0, push} - {3'h0, pop};
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			for (int i = 0; i < RPLY_DEPTH; i++) begin
				rb_q[i]    <= '0;
				stamp_q[i] <= '0;
			end
			state_q     <= ST_RUN;
			head_q      <= '0;
			tail_q      <= '0;
			rp_q        <= '0;
			left_q      <= '0;
			cnt_q       <= '0;
			now_q       <= '0;
			frst_q      <= '0;
			busy_q      <= '0;
			ref_cnt_q   <= TREF_RST;
			ref_pend_q  <= 1'b0;
			ref_rank_q  <= '0;
			retried_q   <= 1'b0;
			hdata_q     <= '0;
			cmd_valid_o <= 1'b0;
			cmd_o       <= '0;
			cpl_valid_o <= 1'b0;
			cpl_o       <= '0;
		end else begin
			rb_q        <= rb_d;
			stamp_q     <= stamp_d;
			state_q     <= state_d;
			head_q      <= head_d;
			tail_q      <= tail_d;
			rp_q        <= rp_d;
			left_q      <= left_d;
			cnt_q       <= cnt_d;
			now_q       <= now_d;
			frst_q      <= frst_d;
			busy_q      <= busy_d;
			ref_cnt_q   <= ref_cnt_d;
			ref_pend_q  <= ref_pend_d;
			ref_rank_q  <= ref_rank_d;
			retried_q   <= retried_d;
			hdata_q     <= hdata_d;
			cmd_valid_o <= cmd_valid_d;
			cmd_o       <= cmd_d;
			cpl_valid_o <= cpl_valid_d;
			cpl_o       <= cpl_d;
		end
	end

	assign fast_reset_o = state_q == ST_FRST;
	assign fatal_o      = state_q == ST_FATAL;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	a_cfg_gate: assert property (cmd_valid_o |-> $past(cfg_done))
		else $error("command issued before configuration");
	a_retire_rtt: assert property (cpl_valid_o && !cpl_o.abort |-> $past(age) >= RTT_CNT && !$past(fail))
		else $error("retired before round trip");
	a_fail_reset: assert property (state_q == ST_RUN && fail && cnt_q != '0 && head.kind != KIND_CFG_RD
		&& !retried_q |=> fast_reset_o [*8])
		else $error("failure did not start fast reset");
	a_second_fatal: assert property (fail && cnt_q != '0 && head.kind != KIND_CFG_RD && retried_q
		&& state_q != ST_FRST |=> fatal_o)
		else $error("second failure not fatal");
	a_cfg_abort: assert property (fail && cnt_q != '0 && head.kind == KIND_CFG_RD && state_q != ST_FRST
		&& state_q != ST_FATAL |=> cpl_valid_o && cpl_o.abort && cpl_o.data == ALL_ONES && !fast_reset_o)
		else $error("config read not aborted with all ones");
	a_bus_idle: assert property (cmd_valid_o && is_col(cmd_o.kind) |=> !cmd_valid_o [*3])
		else $error("burst interrupted");
	a_size_64: assert property (cmd_valid_o |-> cmd_o.bytes == ACCESS_SZ && cmd_o.burst_len == BURST_LEN)
		else $error("access size not 64 bytes");
	a_ref_rotate: assert property (cmd_valid_o && cmd_o.kind == KIND_REF |-> cmd_o.rank == ref_rank_q - 3'h1)
		else $error("refresh rank not rotating");
	a_replay_hold: assert property (state_q != ST_RUN |-> !req_ready_o)
		else $error("new request taken during recovery");
	a_reset_quiet: assert property (fast_reset_o |-> !cmd_valid_o ##1 1'b1)
		else $error("command during fast reset");

	c_fast_reset: cover property (fast_reset_o ##1 state_q == ST_REPLAY);
	c_replay_done: cover property (state_q == ST_REPLAY ##1 state_q == ST_RUN);
	c_cfg_abort: cover property (cpl_valid_o && cpl_o.abort);
	c_fatal: cover property ($rose(fatal_o));
endmodule // mcer_channel

// File: hdl/mcer_ecc_log.sv
`timescale 1ns/1ps
module mcer_ecc_log (
	input  wire logic                   clk_sys_i,
	input  wire logic                   srst_i,
	input  wire mcer_pkg::mcer_ecc_evt_s evt_i,
	input  wire logic                   single_i,
	input  wire logic                   ferr_clr_i,
	input  wire logic [143:0]           xfer0_i,
	input  wire logic [143:0]           xfer1_i,
	input  wire logic                   crit_upper_i,
	output logic      [255:0]           data_symbols_o,
	output logic      [31:0]            check_symbols_o,
	output logic                        ferr_valid_o,
	output logic      [1:0]             chan_idx_o,
	output logic      [2:0]             rec_rank_o,
	output logic      [17:0]            rec_loc_o,
	output logic      [2:0]             nrec_rank_o
);
	import mcer_pkg::*;

	function automatic logic [17:0] pair_of(input logic [35:0] m);
		logic [17:0] p;
		p = '0;
		for (int k = 0; k < PAIR_NUM; k++) begin
			p[k] = m[2*k] | m[2*k+1];
		end
		return p;
	endfunction

	// ----------------------------------------
	// Symbol assembly
	// ----------------------------------------
	logic [287:0] sym_d, sym_q;
	genvar s;
	generate
		for (s = 0; s < SYM_NUM; s++) begin : g_sym
			assign sym_d[8*s +: 8] = crit_upper_i ? {xfer0_i[4*s +: 4], xfer1_i[4*s +: 4]}
			                                      : {xfer1_i[4*s +: 4], xfer0_i[4*s +: 4]};
		end
	endgenerate
	assign data_symbols_o  = sym_q[8*DS_NUM-1:0];
	assign check_symbols_o = sym_q[287:8*DS_NUM];

	// ----------------------------------------
	// Error logs
	// ----------------------------------------
	logic [17:0] pairs;
	logic        corr;
	logic        fv_d, fv_q;
	logic [1:0]  ci_d, ci_q;
	logic [2:0]  rr_d, rr_q, nr_d, nr_q;
	logic [17:0] rl_d, rl_q;

	always_comb begin
		pairs = pair_of(evt_i.sym_mask);
		corr  = $onehot(pairs) && !(single_i && (pairs[17:9] != '0));
		fv_d  = fv_q;
		ci_d  = ci_q;
		rr_d  = rr_q;
		rl_d  = rl_q;
		nr_d  = nr_q;
		if (ferr_clr_i) begin
			fv_d = 1'b0;
		end
		if (evt_i.valid) begin
			if (corr) begin
				rr_d = evt_i.rank;
				rl_d = pairs;
			end else begin
				nr_d = evt_i.rank;
			end
			if (!fv_q || ferr_clr_i) begin
				fv_d = 1'b1;
				ci_d = evt_i.branch ? CHIDX_BR1 : CHIDX_BR0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sym_q <= '0;
			fv_q  <= 1'b0;
			ci_q  <= '0;
			rr_q  <= '0;
			rl_q  <= '0;
			nr_q  <= '0;
		end else begin
			sym_q <= sym_d;
			fv_q  <= fv_d;
			ci_q  <= ci_d;
			rr_q  <= rr_d;
			rl_q  <= rl_d;
			nr_q  <= nr_d;
		end
	end

	assign ferr_valid_o = fv_q;
	assign chan_idx_o   = ci_q;
	assign rec_rank_o   = rr_q;
	assign rec_loc_o    = rl_q;
	assign nrec_rank_o  = nr_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_chan_branch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		evt_i.valid && !fv_q |=> chan_idx_o == {$past(evt_i.branch), 1'b0})
		else $error("channel index does not follow branch");
	a_loc_pair: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		evt_i.valid && evt_i.sym_mask == 36'h0_0000_0003 |=> rec_loc_o == 18'h0_0001)
		else $error("whole-device error not logged as one pair");
	a_uncorr_rank: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		evt_i.valid && !corr |=> nrec_rank_o == $past(evt_i.rank))
		else $error("uncorrectable rank not logged");
endmodule // mcer_ecc_log

// File: hdl/mcer_pkg.sv
package mcer_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ      = 50;
	localparam int unsigned RTT_NS       = 400;
	localparam int unsigned RTT_CYC      = (RTT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned FRST_NS      = 2000;
	localparam int unsigned FRST_CYC     = (FRST_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  RTT_CNT      = 8'(RTT_CYC);
	localparam logic [7:0]  FRST_CNT     = 8'(FRST_CYC);
	// ----------------------------------------
	// Access geometry
	// ----------------------------------------
	localparam int unsigned ACCESS_BYTES = 64;
	localparam int unsigned BURST_BYTES  = 32;
	localparam int unsigned BURST_XFERS  = 4;
	localparam logic [2:0]  BUSY_CNT     = 3'(ACCESS_BYTES / BURST_BYTES * BURST_XFERS / 2);
	localparam logic [6:0]  ACCESS_SZ    = 7'(ACCESS_BYTES);
	localparam logic [2:0]  BURST_LEN    = 3'(BURST_XFERS);
	localparam logic [3:0]  RPLY_DEPTH   = 4'h8;
	localparam int unsigned NUM_RANKS    = 8;
	// ----------------------------------------
	// ECC layout
	// ----------------------------------------
	localparam int unsigned DS_NUM       = 32;
	localparam int unsigned CS_NUM       = 4;
	localparam int unsigned SYM_NUM      = DS_NUM + CS_NUM;
	localparam int unsigned PAIR_NUM     = SYM_NUM / 2;
	localparam int unsigned PAIR_EVEN    = PAIR_NUM / 2;
	localparam int unsigned SC_CW_BYTES  = 9;
	localparam int unsigned SC_CW_LINE   = 8;
	localparam logic [1:0]  CHIDX_BR0    = 2'h0;
	localparam logic [1:0]  CHIDX_BR1    = 2'h2;
	localparam logic [31:0] ALL_ONES     = 32'hFFFF_FFFF;
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_FERR     = 8'h08;
	localparam logic [7:0]  REG_RECA     = 8'h0C;
	localparam logic [7:0]  REG_RECB     = 8'h10;
	localparam logic [7:0]  REG_NRECA    = 8'h14;
	localparam int unsigned CTRL_CFGDONE = 0;
	localparam int unsigned CTRL_SINGLE  = 1;
	localparam int unsigned CTRL_TREF    = 16;
	localparam int unsigned FERR_VALID   = 2;
	localparam logic [15:0] TREF_RST     = 16'h0186;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {KIND_RD, KIND_WR, KIND_CFG_RD, KIND_CFG_WR, KIND_REF} mcer_kind_e;
	typedef enum logic [1:0] {ST_RUN, ST_FRST, ST_REPLAY, ST_FATAL} mcer_state_e;
	typedef struct packed {
		mcer_kind_e  kind;
		logic [3:0]  tag;
		logic [2:0]  rank;
		logic [31:0] addr;
	} mcer_req_s;
	typedef struct packed {
		mcer_kind_e  kind;
		logic [3:0]  tag;
		logic [2:0]  rank;
		logic [31:0] addr;
		logic        crit_upper;
		logic        posted_cas;
		logic [2:0]  burst_len;
		logic [6:0]  bytes;
	} mcer_cmd_s;
	typedef struct packed {
		logic        valid;
		logic        crc_ok;
		logic        alert;
		logic        is_ack;
		logic        ack_ok;
		logic [31:0] data;
	} mcer_nb_s;
	typedef struct packed {
		logic [3:0]  tag;
		logic        abort;
		logic [31:0] data;
	} mcer_cpl_s;
	typedef struct packed {
		logic        valid;
		logic        branch;
		logic [2:0]  rank;
		logic [35:0] sym_mask;
	} mcer_ecc_evt_s;
endpackage

// File: verif/mcer_dimm_model.sv
`timescale 1ns/1ps
module mcer_dimm_model
	import mcer_pkg::*;
#(
	parameter int LAT = 6
) (
	input  wire logic      clk_sys_i,
	input  wire logic      srst_i,
	input  wire logic      cmd_valid_i,
	input  wire mcer_cmd_s cmd_i,
	input  wire logic      fast_reset_i,
	input  wire logic      fail_i,
	output mcer_nb_s       nb_o,
	output logic           proto_err_o
);
	// ----
	// Frame return
	// ----
	logic [LAT-1:0] pv_q;
	logic [LAT-1:0] pf_q;
	logic [LAT-1:0] pa_q;
	logic [31:0]    cnt_q;
	logic           v;
	initial proto_err_o = 1'b0;
	always @(posedge clk_sys_i) begin
		cnt_q <= srst_i ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
		pv_q  <= {pv_q[LAT-2:0], cmd_valid_i && cmd_i.kind != KIND_REF};
		pf_q  <= {pf_q[LAT-2:0], fail_i};
		pa_q  <= {pa_q[LAT-2:0], cmd_i.kind == KIND_WR || cmd_i.kind == KIND_CFG_WR};
		if (srst_i || fast_reset_i) begin // Self-refresh, nothing returned
			pv_q <= '0;
		end
		if (cmd_valid_i && (fast_reset_i || cmd_i.burst_len != 3'h4)) begin
			proto_err_o <= 1'b1;
		end
	end
	assign v = pv_q[LAT-1];
	always_comb begin
		nb_o        = '0;
		nb_o.valid  = v;
		nb_o.is_ack = pa_q[LAT-1];
		nb_o.crc_ok = 1'b1;
		nb_o.ack_ok = !(v && pf_q[LAT-1] && pa_q[LAT-1]);
		nb_o.data   = v ? cnt_q : ~cnt_q;
		if (v && pf_q[LAT-1] && !pa_q[LAT-1]) begin // Alert, bad CRC, no data
			nb_o.alert  = 1'b1;
			nb_o.crc_ok = 1'b0;
			nb_o.data   = ~cnt_q;
		end
	end
endmodule // mcer_dimm_model

// File: verif/tb_mcer_channel.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module tb_mcer_channel
	import mcer_pkg::*;
;
	logic          clk_sys_i = 1'b0;
	logic          srst_i = 1'b1;
	logic [7:0]    reg_addr_i = '0;
	logic [31:0]   reg_wdata_i = '0;
	logic          reg_we_i = 1'b0;
	logic          reg_re_i = 1'b0;
	logic [31:0]   reg_rdata_o;
	logic          req_valid_i = 1'b0;
	mcer_req_s     req_i = '0;
	logic          req_ready_o;
	logic          cmd_valid_o;
	mcer_cmd_s     cmd_o;
	mcer_nb_s      nb_i;
	mcer_ecc_evt_s ecc_evt_i = '0;
	logic [143:0]  xfer0_i = '0;
	logic [143:0]  xfer1_i = '0;
	logic          xfer_upper_i = 1'b0;
	logic [255:0]  data_symbols_o;
	logic [31:0]   check_symbols_o;
	logic          cpl_valid_o;
	mcer_cpl_s     cpl_o;
	logic          fast_reset_o;
	logic          fatal_o;
	logic          fail = 1'b0;
	logic          perr;
	logic          frst_seen = 1'b0;
	logic [31:0]   rd_d;
	int            n_fail = 0;
	int            checks_done = 0;
	mcer_cmd_s     rq[$];
	logic [2:0]    fq[$];
	mcer_cpl_s     cq[$];
	int            k;
	int            n;

	always #10 clk_sys_i = ~clk_sys_i;

	mcer_channel i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .cmd_valid_o(cmd_valid_o),
		.cmd_o(cmd_o), .nb_i(nb_i), .ecc_evt_i(ecc_evt_i), .xfer0_i(xfer0_i), .xfer1_i(xfer1_i),
		.xfer_upper_i(xfer_upper_i), .data_symbols_o(data_symbols_o), .check_symbols_o(check_symbols_o),
		.cpl_valid_o(cpl_valid_o), .cpl_o(cpl_o), .fast_reset_o(fast_reset_o), .fatal_o(fatal_o));
	mcer_dimm_model i_dimm (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_o),
		.cmd_i(cmd_o), .fast_reset_i(fast_reset_o), .fail_i(fail), .nb_o(nb_i), .proto_err_o(perr));

	// ----
	// Monitors and bus tasks
	// ----
	always @(negedge clk_sys_i) begin
		if (cmd_valid_o === 1'b1 && cmd_o.kind == KIND_REF) fq.push_back(cmd_o.rank);
		else if (cmd_valid_o === 1'b1) rq.push_back(cmd_o);
		if (cpl_valid_o === 1'b1) cq.push_back(cpl_o);
		if (fast_reset_o === 1'b1) frst_seen = 1'b1;
	end
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_we_i    <= 1'b1;
		@(posedge clk_sys_i);
		reg_we_i    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge clk_sys_i);
		reg_re_i   <= 1'b0;
		@(negedge clk_sys_i);
		rd_d = reg_rdata_o;
	endtask
	task automatic req(input mcer_kind_e t, input logic [3:0] g, input logic [31:0] a);
		int w = 0;
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		req_i       <= '{kind: t, tag: g, rank: g[2:0], addr: a};
		@(negedge clk_sys_i);
		while (req_ready_o !== 1'b1 && w < 500) begin
			w++;
			@(negedge clk_sys_i);
		end
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		`CHK("req_taken", 1'b1, w < 500)
	endtask
	task automatic wait_cpl(input int c);
		for (k = 0; k < 300 && cq.size() < c; k++) @(negedge clk_sys_i);
		`CHK("cpl_count", c, cq.size())
	endtask
	task automatic ecc(input logic b, input logic [2:0] r, input logic [35:0] m);
		@(posedge clk_sys_i);
		ecc_evt_i <= '{valid: 1'b1, branch: b, rank: r, sym_mask: m};
		@(posedge clk_sys_i);
		ecc_evt_i <= '0;
		cyc(2);
	endtask
	task automatic do_reset();
		srst_i <= 1'b1;
		cyc(20);
		srst_i <= 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_idle();
		rd(REG_CTRL);
		`CHK("tref_rst", TREF_RST, rd_d[31:16])
		rd(8'h40);
		`CHK("unmapped", 32'h0000_0000, rd_d)
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		cyc(30);
		req_valid_i <= 1'b0;
		`CHK("no_cmd", 0, rq.size() + fq.size())
		$display("test idle done");
	endtask
	task automatic t_ecc();
		ecc(1'b1, 3'h5, 36'h0_000C_0000);
		rd(REG_FERR);
		`CHK("idx_br1", 3'h6, rd_d[2:0])
		rd(REG_RECB);
		`CHK("loc_odd", 10'h200, rd_d[9:0])
		rd(REG_RECA);
		`CHK("rec_rank", 3'h5, rd_d[2:0])
		wr(REG_FERR, 32'h0000_0004);
		ecc(1'b0, 3'h2, 36'h0_0000_0003);
		rd(REG_FERR);
		`CHK("idx_br0", 3'h4, rd_d[2:0])
		rd(REG_RECB);
		`CHK("loc_even", 10'h001, rd_d[9:0])
		ecc(1'b0, 3'h6, 36'h0_0000_0011);
		rd(REG_NRECA);
		`CHK("nrec_rank", 3'h6, rd_d[2:0])
		wr(REG_CTRL, {TREF_RST, 16'h0002});
		ecc(1'b1, 3'h3, 36'h0_000C_0000);
		rd(REG_NRECA);
		`CHK("single_odd", 3'h3, rd_d[2:0])
		$display("test ecc done");
	endtask
	task automatic t_xfer(input logic up, input logic [7:0] s);
		@(posedge clk_sys_i);
		xfer0_i      <= {36{4'h3}};
		xfer1_i      <= {36{4'hC}};
		xfer_upper_i <= up;
		cyc(3);
		`CHK("data_sym", {32{s}}, data_symbols_o)
		`CHK("check_sym", {4{s}}, check_symbols_o)
		$display("test layout done");
	endtask
	task automatic t_read();
		wr(REG_CTRL, {TREF_RST, 16'h0001});
		req(KIND_RD, 4'h1, 32'h0000_0010);
		req(KIND_RD, 4'h2, 32'h0000_0000);
		wait_cpl(2);
		`CHK("bytes", ACCESS_SZ, rq[0].bytes)
		`CHK("blen", BURST_LEN, rq[0].burst_len)
		`CHK("pcas", 1'b1, rq[1].posted_cas)
		`CHK("crit_hi", 1'b1, rq[0].crit_upper)
		`CHK("crit_lo", 1'b0, rq[1].crit_upper)
		`CHK("cpl_ok", 5'h02, {cq[0].tag, cq[0].abort})
		`CHK("cpl_tag", 4'h2, cq[1].tag)
		$display("test read done");
	endtask
	task automatic t_cfg();
		rq.delete();
		cq.delete();
		frst_seen = 1'b0;
		fail <= 1'b1;
		req(KIND_CFG_RD, 4'h5, 32'h0000_0000);
		wait_cpl(1);
		fail <= 1'b0;
		cyc(40);
		`CHK("abort", 1'b1, cq[0].abort)
		`CHK("ones", ALL_ONES, cq[0].data)
		`CHK("no_frst", 1'b0, frst_seen)
		`CHK("no_retry", 1, rq.size())
		$display("test cfg done");
	endtask
	task automatic t_replay();
		rq.delete();
		cq.delete();
		fail <= 1'b1;
		req(KIND_WR, 4'h3, 32'h0000_0040);
		@(posedge clk_sys_i);
		fail <= 1'b0;
		req(KIND_RD, 4'h4, 32'h0000_0080);
		for (k = 0; k < 100 && fast_reset_o !== 1'b1; k++) @(negedge clk_sys_i);
		for (n = 0; n < 300 && fast_reset_o === 1'b1; n++) @(negedge clk_sys_i);
		`CHK("frst_len", FRST_CYC, n)
		wait_cpl(1);
		`CHK("cpl_tag", 4'h4, cq[0].tag)
		`CHK("replay_n", 1'b1, rq.size() >= 4)
		`CHK("replay_1", 4'h3, rq[2].tag)
		`CHK("replay_2", 4'h4, rq[3].tag)
		$display("test replay done");
	endtask
	task automatic t_refresh();
		wr(REG_CTRL, 32'h0020_0001);
		fq.delete();
		for (k = 0; k < 1200 && fq.size() < 8; k++) @(negedge clk_sys_i);
		`CHK("ref_cnt", 1'b1, fq.size() >= 8)
		for (k = 0; k < 7; k++) `CHK("ref_rot", fq[k] + 3'h1, fq[k+1])
		$display("test refresh done");
	endtask
	task automatic t_fatal();
		fail <= 1'b1;
		req(KIND_RD, 4'h7, 32'h0000_0100);
		for (k = 0; k < 600 && fatal_o !== 1'b1; k++) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
		fail <= 1'b0;
		`CHK("fatal", 1'b1, fatal_o)
		do_reset();
		`CHK("fatal_clr", 1'b0, fatal_o)
		`CHK("far_side", 1'b0, perr)
		$display("test fatal done");
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_fail++;
		complete_run();
	end
	initial begin
		do_reset();
		t_idle();
		t_ecc();
		t_xfer(1'b0, 8'hC3);
		t_xfer(1'b1, 8'h3C);
		t_read();
		t_cfg();
		t_replay();
		t_refresh();
		t_fatal();
		complete_run();
	end
endmodule // tb_mcer_channel
